// ---- shared/usc_pkg.sv ----
// Package: register map, field positions, reset values and types of the serial control block
package usc_pkg;

  // Register byte offsets on the bus
  localparam logic [7:0] ADDR_CTRL_TWO = 8'h00;
  localparam logic [7:0] ADDR_STATUS_ONE = 8'h04;
  localparam logic [7:0] ADDR_DATA = 8'h08;
  localparam logic [7:0] ADDR_CTRL_ONE = 8'h0c;
  localparam logic [7:0] ADDR_EVT_STATUS = 8'h10;
  localparam logic [7:0] ADDR_EVT_MASK = 8'h14;

  // Control-two field positions
  localparam int C2_TX_IRQ_EN = 7;
  localparam int C2_TX_ON = 3;
  localparam int C2_RX_ON = 2;
  localparam int C2_RX_STANDBY = 1;
  localparam int C2_QUEUE_BREAK = 0;

  // Control-one field positions (own register)
  localparam int C1_WRAP_MODE = 0;
  localparam int C1_WAKE_KIND = 1;
  localparam int C1_LONG_BREAK = 2;
  localparam int C1_NINE_BIT = 3;
  localparam int C1_PARITY_ON = 4;

  // Status-one field position
  localparam int S1_TX_EMPTY = 7;

  // Event status/mask field positions
  localparam int EV_TX_EMPTY = 0;
  localparam int EV_WAKE = 1;
  localparam int EV_BREAK_DONE = 2;

  // Reset values
  localparam logic [7:0] RST_CTRL_TWO = 8'h00;
  localparam logic [7:0] RST_CTRL_ONE = 8'h00;
  localparam logic [7:0] RST_STATUS_ONE = 8'h80;
  localparam logic [2:0] RST_EVT = 3'h0;

  // Break lengths in bit times: base for 8-bit no parity frame
  localparam logic [3:0] BRK_BASE = 4'ha;
  localparam logic [3:0] BRK_LONG_BASE = 4'hd;

  // Transmit sequencer states
  typedef enum logic [2:0] {
    USC_TX_IDLE = 3'b001,
    USC_TX_DATA = 3'b010,
    USC_TX_BRK = 3'b100
  } usc_tx_state_t;

  // Line-side pin bundle: serial output and pin ownership
  typedef struct packed {
    logic txd;
    logic tx_own;
    logic rx_own;
  } usc_pins_t;

  // Receiver events from the framing logic
  typedef struct packed {
    logic char_done;
    logic msb;
    logic idle_line;
  } usc_rx_evt_t;

endpackage : usc_pkg

// ---- src/usc_ctrl.sv ----
// Control and status logic of the serial transceiver with an AHB-Lite register slave
//
// The placing of the registers and the AHB-Lite interface to the registers are this design's own decisions.
`timescale 1ns/100ps
`default_nettype none
module usc_ctrl (
  // Clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [7:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // Bit-time enable from the baud divider
  input wire logic bit_tick,
  // Receiver events from framing logic
  input wire usc_pkg::usc_rx_evt_t rx_evt,
  // Line side
  output usc_pkg::usc_pins_t pins,
  output logic rx_char_flag,
  output logic irq
);
  import usc_pkg::*;

  logic [7:0] ctrl_two;
  logic [7:0] ctrl_one;
  logic [7:0] tx_buf;
  logic [8:0] tx_shift;
  logic tx_empty;
  logic tx_armed;
  logic [2:0] evt_status;
  logic [2:0] evt_mask;
  logic brk_pending;
  logic [3:0] bit_cnt;
  usc_tx_state_t tx_state;
  logic ap_valid;
  logic ap_write;
  logic [7:0] ap_addr;

  ////////////////////////////////////////////////////////////////////////////
  // Bus decode

  // Break length in bit times from frame format
  function automatic logic [3:0] brk_len(input logic [7:0] c1);
    logic [3:0] base;
    base = c1[C1_LONG_BREAK] ? BRK_LONG_BASE : BRK_BASE;
    brk_len = base + 4'(c1[C1_NINE_BIT]) + 4'(c1[C1_PARITY_ON]);
  endfunction : brk_len

  logic wr_en;
  logic rd_en;
  logic wr_ctrl_two;
  logic wr_data;
  logic [7:0] wdata8;
  logic [3:0] next_bit_cnt;
  assign wr_en = ap_valid && ap_write;
  assign rd_en = hsel && hready && htrans[1] && !hwrite;
  assign wr_ctrl_two = wr_en && (ap_addr == ADDR_CTRL_TWO);
  assign wr_data = wr_en && (ap_addr == ADDR_DATA);
  assign wdata8 = hwdata[7:0];
  assign next_bit_cnt = bit_cnt - 4'h1;

  // Address phase capture; zero wait states so hreadyout stays high
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      ap_valid <= 1'b0;
      ap_write <= 1'b0;
      ap_addr <= 8'h00;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      ap_valid <= hsel && hready && htrans[1];
      ap_write <= hwrite;
      ap_addr <= haddr;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end

  // Read data registered at the address phase; unmapped reads return zero
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      hrdata <= 32'h0000_0000;
    end else if (rd_en) begin
      case (haddr)
        ADDR_CTRL_TWO: hrdata <= {24'h00_0000, ctrl_two};
        ADDR_STATUS_ONE: hrdata <= {24'h00_0000, tx_empty, 7'h00};
        ADDR_DATA: hrdata <= {24'h00_0000, tx_buf};
        ADDR_CTRL_ONE: hrdata <= {24'h00_0000, ctrl_one};
        ADDR_EVT_STATUS: hrdata <= {29'h0000_0000, evt_status};
        ADDR_EVT_MASK: hrdata <= {29'h0000_0000, evt_mask};
        default: hrdata <= 32'h0000_0000;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Control registers

  logic wake_hit;
  // Wake-up selection: idle line or address mark, only while in standby
  assign wake_hit = ctrl_two[C2_RX_STANDBY] && (ctrl_one[C1_WAKE_KIND] ?
                    (rx_evt.char_done && rx_evt.msb) : rx_evt.idle_line);

  // Control two; the hardware clear of standby wins unless the write sets it anew
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      ctrl_two <= RST_CTRL_TWO;
    end else if (wr_ctrl_two) begin
      ctrl_two <= wdata8;
    end else if (wake_hit) begin
      ctrl_two[C2_RX_STANDBY] <= 1'b0;
    end
  end

  // Control one: wrap mode, wake kind, break length and frame format
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      ctrl_one <= RST_CTRL_ONE;
    end else if (wr_en && ap_addr == ADDR_CTRL_ONE) begin
      ctrl_one <= wdata8;
    end
  end

  // Mask register gating events onto irq
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      evt_mask <= RST_EVT;
    end else if (wr_en && ap_addr == ADDR_EVT_MASK) begin
      evt_mask <= wdata8[2:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Transmit buffer empty flag

  logic tx_start;
  logic brk_end;
  logic buf_to_shift;
  // Frames start only on a bit tick, so a start bit or break never runs short
  assign tx_start = (tx_state == USC_TX_IDLE) && ctrl_two[C2_TX_ON] && bit_tick;
  assign brk_end = (tx_state == USC_TX_BRK) && bit_tick && (bit_cnt == 4'h1);
  assign buf_to_shift = tx_start && !tx_empty && !brk_pending;

  // Arm on a status read that sees the flag set; data write then clears it
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      tx_armed <= 1'b0;
    end else if (rd_en && haddr == ADDR_STATUS_ONE && tx_empty) begin
      tx_armed <= 1'b1;
    end else if (wr_data) begin
      tx_armed <= 1'b0;
    end
  end

  // Writes to status one are ignored; set by buffer hand-off beats the clear
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      tx_empty <= RST_STATUS_ONE[S1_TX_EMPTY];
    end else if (buf_to_shift) begin
      tx_empty <= 1'b1;
    end else if (wr_data && tx_armed) begin
      tx_empty <= 1'b0;
    end
  end

  // Buffer accepts data on any data write
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      tx_buf <= 8'h00;
    end else if (wr_data) begin
      tx_buf <= wdata8;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Break queuing and transmit sequencer

  // A break is queued on setting the bit; it is used up when a break starts or runs on
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      brk_pending <= 1'b0;
    end else if (wr_ctrl_two && wdata8[C2_QUEUE_BREAK] && !ctrl_two[C2_QUEUE_BREAK]) begin
      brk_pending <= 1'b1;
    end else if ((tx_start && brk_pending) || (brk_end && ctrl_two[C2_QUEUE_BREAK])) begin
      brk_pending <= 1'b0;
    end
  end

  // Sequencer: start bit, data bits, stop, or a break of zeros
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      tx_state <= USC_TX_IDLE;
      bit_cnt <= 4'h0;
      tx_shift <= 9'h1ff;
    end else begin
      case (tx_state)
        USC_TX_IDLE: begin
          if (tx_start && brk_pending) begin
            tx_state <= USC_TX_BRK;
            bit_cnt <= brk_len(ctrl_one);
          end else if (buf_to_shift) begin
            tx_state <= USC_TX_DATA;
            tx_shift <= {tx_buf, 1'b0};
            bit_cnt <= 4'ha;
          end
        end
        USC_TX_DATA: begin
          if (bit_tick) begin
            tx_shift <= {1'b1, tx_shift[8:1]};
            bit_cnt <= next_bit_cnt;
            if (bit_cnt == 4'h1) begin
              tx_state <= USC_TX_IDLE;
            end
          end
        end
        USC_TX_BRK: begin
          // A held bit runs straight into the next break with no idle bit between
          if (brk_end && ctrl_two[C2_QUEUE_BREAK]) begin
            bit_cnt <= brk_len(ctrl_one);
          end else if (brk_end) begin
            tx_state <= USC_TX_IDLE;
          end else if (bit_tick) begin
            bit_cnt <= next_bit_cnt;
          end
        end
        default: tx_state <= USC_TX_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pins, receive flag, interrupts

  // Pin ownership; the transmitter stays on the pin until a frame finishes
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      pins <= '0;
    end else begin
      pins.tx_own <= ctrl_two[C2_TX_ON] || (tx_state != USC_TX_IDLE);
      pins.txd <= (tx_state == USC_TX_BRK) ? 1'b0
                : (tx_state == USC_TX_DATA) ? tx_shift[0] : 1'b1;
      pins.rx_own <= ctrl_two[C2_RX_ON] && !ctrl_one[C1_WRAP_MODE];
    end
  end

  // Received-character pulse is blocked while the receiver sleeps
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      rx_char_flag <= 1'b0;
    end else begin
      rx_char_flag <= rx_evt.char_done && !ctrl_two[C2_RX_STANDBY];
    end
  end

  logic [2:0] evt_set;
  assign evt_set = {brk_end, wake_hit,
                    buf_to_shift};

  // Sticky events cleared by write-one; a new event wins over the clear
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      evt_status <= RST_EVT;
    end else if (wr_en && ap_addr == ADDR_EVT_STATUS) begin
      evt_status <= (evt_status & ~wdata8[2:0]) | evt_set;
    end else begin
      evt_status <= evt_status | evt_set;
    end
  end

  // Level interrupt: buffer-empty request plus unmasked sticky events
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      irq <= 1'b0;
    end else begin
      irq <= (ctrl_two[C2_TX_IRQ_EN] && tx_empty) || |(evt_status & evt_mask);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  chk_rx_pin_release: assert property (@(posedge mclk) disable iff (sys_rst)
    ctrl_one[C1_WRAP_MODE] |=> !pins.rx_own)
    else $error("rx pin held in wrap mode");
  chk_rx_pin_off: assert property (@(posedge mclk) disable iff (sys_rst)
    !ctrl_two[C2_RX_ON] |=> !pins.rx_own)
    else $error("rx pin held with receiver off");
  chk_tx_pin_own: assert property (@(posedge mclk) disable iff (sys_rst)
    ctrl_two[C2_TX_ON] |=> pins.tx_own)
    else $error("tx pin not owned");
  chk_wake_clears: assert property (@(posedge mclk) disable iff (sys_rst)
    (wake_hit && !wr_ctrl_two) |=> !ctrl_two[C2_RX_STANDBY])
    else $error("standby not cleared on wake");
  chk_break_zero: assert property (@(posedge mclk) disable iff (sys_rst)
    (tx_state == USC_TX_BRK) |=> (pins.txd == 1'b0))
    else $error("break not driving zero");
  chk_empty_set: assert property (@(posedge mclk) disable iff (sys_rst)
    buf_to_shift |=> tx_empty)
    else $error("empty flag not set on hand-off");
  chk_empty_clear: assert property (@(posedge mclk) disable iff (sys_rst)
    ($fell(tx_empty)) |-> $past(wr_data) && $past(tx_armed))
    else $error("empty flag cleared without sequence");
  chk_irq_tx: assert property (@(posedge mclk) disable iff (sys_rst)
    (ctrl_two[C2_TX_IRQ_EN] && tx_empty) |=> irq)
    else $error("tx irq missing");
  chk_standby_quiet: assert property (@(posedge mclk) disable iff (sys_rst)
    (ctrl_two[C2_RX_STANDBY] && rx_evt.char_done) |=> !rx_char_flag)
    else $error("rx flag during standby");
  chk_break_start: assert property (@(posedge mclk) disable iff (sys_rst)
    (tx_start && brk_pending) |=> (tx_state == USC_TX_BRK))
    else $error("queued break not started");
  chk_break_repeat: assert property (@(posedge mclk) disable iff (sys_rst)
    (brk_end && ctrl_two[C2_QUEUE_BREAK]) |=> (tx_state == USC_TX_BRK))
    else $error("held break bit did not repeat");

endmodule : usc_ctrl
`default_nettype wire

// ---- verif/usc_remote.sv ----
// Remote serial device model: line listener and receive-event source
`timescale 1ns/100ps
`default_nettype none
module usc_remote (
  // Clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  // Line side
  input wire logic bit_tick,
  input wire usc_pkg::usc_pins_t pins,
  output usc_pkg::usc_rx_evt_t rx_evt,
  // Bench commands for receive events
  input wire logic ev_char,
  input wire logic ev_msb,
  input wire logic ev_idle,
  // Observed runs of zero bit times
  output logic [7:0] cur_run,
  output logic [7:0] last_run,
  output logic [7:0] n_run
);
  import usc_pkg::*;
  logic line;

  ////////////////////////////////////////////////////////////////////////////
  // A released pin floats high through the pull-up, so reset junk on txd is unseen
  assign line = pins.tx_own ? pins.txd : 1'b1;

  // Count bit times at zero; a run closes at the first high bit
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      cur_run <= 8'h00;
      last_run <= 8'h00;
      n_run <= 8'h00;
    end else if (bit_tick) begin
      if (line == 1'b0) begin
        cur_run <= cur_run + 8'h01;
      end else if (cur_run != 8'h00) begin
        last_run <= cur_run;
        cur_run <= 8'h00;
        n_run <= n_run + 8'h01;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Framing events as one-cycle pulses; msb is garbage outside a character
  always_ff @(posedge mclk) begin
    rx_evt <= '{char_done: ev_char, msb: ev_char ? ev_msb : ~ev_msb, idle_line: ev_idle};
  end
endmodule : usc_remote
`default_nettype wire

// ---- verif/tb.sv ----
// Testbench of the serial control block: bus tasks and directed tests
`timescale 1ns/100ps
`default_nettype none
`define CHK(got, exp) begin samples_checked++; if ((got) !== (exp)) begin n_mismatch++; \
  $display("ERROR t=%0t got=%h exp=%h", $time, (got), (exp)); end end
module tb;
  import usc_pkg::*;
  logic mclk, sys_rst, hsel, hwrite, ev_char, ev_msb, ev_idle, hreadyout, hresp, irq;
  logic bit_tick = 1'b0;
  logic rx_char_flag;
  logic [7:0] haddr, cur_run, last_run, n_run, n0, brk;
  logic [1:0] htrans;
  logic [1:0] tick_cnt = 2'd0;
  logic [2:0] hsize;
  logic [31:0] hwdata, hrdata, r;
  wire logic hready;
  usc_rx_evt_t rx_evt;
  usc_pins_t pins;
  int n_mismatch, samples_checked, n_flag, nf;
  logic [7:0] cfg [5] = '{8'h00, 8'h08, 8'h18, 8'h04, 8'h1c};

  ////////////////////////////////////////////////////////////////////////////
  // The single slave's hreadyout is the bus ready
  assign hready = hreadyout;
  usc_ctrl DUT (.mclk(mclk), .sys_rst(sys_rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .bit_tick(bit_tick), .rx_evt(rx_evt),
    .pins(pins), .rx_char_flag(rx_char_flag), .irq(irq));
  usc_remote remote (.mclk(mclk), .sys_rst(sys_rst), .bit_tick(bit_tick), .pins(pins),
    .rx_evt(rx_evt), .ev_char(ev_char), .ev_msb(ev_msb), .ev_idle(ev_idle),
    .cur_run(cur_run), .last_run(last_run), .n_run(n_run));

  // Clock, and a bit time of four clocks to keep frames short
  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    tick_cnt <= tick_cnt + 2'd1;
    bit_tick <= (tick_cnt == 2'd3);
    if (rx_char_flag === 1'b1) n_flag++;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Single word transfer: address phase, then data phase, each until ready
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= a;
    hwrite <= w;
    hsize <= 3'b010;
    @(posedge mclk);
    while (hreadyout !== 1'b1) @(posedge mclk);
    htrans <= 2'b00;
    hsel <= 1'b0;
    hwdata <= d;
    @(posedge mclk);
    while (hreadyout !== 1'b1) @(posedge mclk);
    r = hrdata;
    `CHK(hresp, 1'b0)
  endtask : bus
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
    repeat (2) @(posedge mclk);
  endtask : wr
  task automatic rd(input logic [7:0] a);
    bus(1'b0, a, 32'h0);
  endtask : rd
  // Wait for the next zero run on the line to close
  task automatic wait_run();
    n0 = n_run;
    while (n_run == n0) @(posedge mclk);
  endtask : wait_run
  task automatic ev(input logic c, input logic m, input logic i);
    ev_char <= c;
    ev_msb <= m;
    ev_idle <= i;
    @(posedge mclk);
    ev_char <= 1'b0;
    ev_msb <= 1'b0;
    ev_idle <= 1'b0;
    repeat (3) @(posedge mclk);
  endtask : ev
  task automatic summarize();
    $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : summarize

  ////////////////////////////////////////////////////////////////////////////
  // Watchdog: whole run needs well under a thousand clocks
  initial begin
    #800000;
    n_mismatch++;
    summarize();
  end

  // Directed tests
  initial begin
    {hsel, hwrite, ev_char, ev_msb, ev_idle, haddr, htrans, hsize, hwdata} = '0;
    sys_rst = 1'b1;
    repeat (2) @(posedge mclk);
    sys_rst <= 1'b0;
    rd(ADDR_CTRL_TWO);
    `CHK(r, 32'h0)
    `CHK(pins.rx_own, 1'b0)
    `CHK(pins.tx_own, 1'b0)
    rd(8'h20);
    `CHK(r, 32'h0)
    // Status writes are ignored and a data write alone does not clear the flag
    wr(ADDR_STATUS_ONE, 32'h0);
    wr(ADDR_DATA, 32'h0);
    rd(ADDR_STATUS_ONE);
    `CHK(r, 32'h80)
    wr(ADDR_DATA, 32'h0);
    rd(ADDR_STATUS_ONE);
    `CHK(r, 32'h0)
    $display("test status done");
    // Enable sends the zero byte: start plus eight zero bits
    wr(ADDR_CTRL_TWO, 32'h0c);
    wait_run();
    `CHK(last_run, 8'd9)
    `CHK(pins.tx_own, 1'b1)
    `CHK(pins.rx_own, 1'b1)
    rd(ADDR_STATUS_ONE);
    `CHK(r, 32'h80)
    rd(ADDR_EVT_STATUS);
    `CHK(r, 32'h01)
    `CHK(irq, 1'b0)
    wr(ADDR_EVT_MASK, 32'h01);
    `CHK(irq, 1'b1)
    wr(ADDR_EVT_STATUS, 32'h01);
    `CHK(irq, 1'b0)
    wr(ADDR_EVT_MASK, 32'h00);
    wr(ADDR_CTRL_TWO, 32'h8c);
    `CHK(irq, 1'b1)
    wr(ADDR_CTRL_TWO, 32'h0c);
    `CHK(irq, 1'b0)
    $display("test transmit done");
    wr(ADDR_CTRL_ONE, 32'h01);
    `CHK(pins.rx_own, 1'b0)
    wr(ADDR_CTRL_ONE, 32'h00);
    `CHK(pins.rx_own, 1'b1)
    $display("test pins done");
    // Break length for five settings: short 8-bit, 9-bit, 9-bit parity; long 8-bit, 9-bit parity
    foreach (cfg[i]) begin
      wr(ADDR_CTRL_ONE, {24'h0, cfg[i]});
      wr(ADDR_CTRL_TWO, 32'h0d);
      wr(ADDR_CTRL_TWO, 32'h0c);
      wait_run();
      brk = (cfg[i][C1_LONG_BREAK] ? 8'd13 : 8'd10) + {7'h0, cfg[i][C1_NINE_BIT]};
      brk = brk + {7'h0, cfg[i][C1_PARITY_ON]};
      `CHK(last_run, brk)
    end
    // Held bit gives back-to-back breaks, merged into one zero run
    wr(ADDR_CTRL_ONE, 32'h0);
    wr(ADDR_CTRL_TWO, 32'h0d);
    while (cur_run < 8'd12) @(posedge mclk);
    wr(ADDR_CTRL_TWO, 32'h0c);
    wait_run();
    `CHK(last_run, 8'd20)
    rd(ADDR_EVT_STATUS);
    `CHK(r, 32'h04)
    wr(ADDR_EVT_STATUS, 32'h04);
    $display("test break done");
    // Standby for each wake kind; the wrong event must not wake
    for (int k = 0; k < 2; k++) begin
      wr(ADDR_CTRL_ONE, {30'h0, k[0], 1'b0});
      wr(ADDR_CTRL_TWO, 32'h0e);
      nf = n_flag;
      ev(1'b1, ~k[0], 1'b0);
      if (k == 1) ev(1'b0, 1'b0, 1'b1);
      `CHK(n_flag, nf)
      rd(ADDR_CTRL_TWO);
      `CHK(r, 32'h0e)
      ev(k[0], k[0], ~k[0]);
      rd(ADDR_CTRL_TWO);
      `CHK(r, 32'h0c)
      nf = n_flag;
      ev(1'b1, 1'b0, 1'b0);
      `CHK(n_flag, nf + 1)
    end
    rd(ADDR_EVT_STATUS);
    `CHK(r, 32'h02)
    $display("test standby done");
    summarize();
  end
endmodule : tb
`default_nettype wire
